// ==== dv/nitrous_stage_rev_limiter_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module nitrous_stage_rev_limiter_test;
  localparam int TICK = 10;  // Short ms tick keeps the run brief
  logic        i_clk, i_srst, i_nitrous_enable, i_arm_trigger, i_staging_trigger;
  logic        i_module_ignition_type, i_cyl_event, i_inj_req, i_coil_req;
  logic [7:0]  i_rel_throttle, i_on_throttle, i_off_throttle, i_stage1_retard, i_stage2_retard;
  logic [15:0] i_rpm, i_max_rpm, i_reenable_ms, i_stage1_min_rpm, i_stage2_min_rpm;
  logic [15:0] i_stage1_delay_ms, i_stage2_delay_ms, i_fuel_limit, i_spark_limit, i_staging_rpm;
  logic        o_stage1_relay, o_stage2_relay, o_lamp, o_inj_drive, o_fuel_cut_flag;
  logic        o_coil_fire, o_spark_cut_flag;
  logic [8:0]  o_retard;
  int          fails, comparisons, t1, t2;

  nitrous_stage_rev_limiter #(.TICK_CYCLES(TICK)) dut_u (.*);
  nos_partner partner_u (.i_clk(i_clk), .i_srst(i_srst), .o_cyl_event(i_cyl_event),
                         .o_inj_req(i_inj_req), .o_coil_req(i_coil_req));

  // ----------------
  // Shared helpers
  // ----------------
  task automatic step(input int n);
    repeat (n) @(negedge i_clk);
  endtask : step

  task automatic compare(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : compare

  task automatic conclude;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // ----------------
  // Scenarios
  // ----------------
  task automatic s_arm_guard;
    i_arm_trigger = 1'b1;
    step(4);
    compare("lamp_guarded", 16'h0000, o_lamp);
    i_arm_trigger = 1'b0;
    i_nitrous_enable = 1'b0;
    step(2);
    i_nitrous_enable = 1'b1;
    step(2);
    i_arm_trigger = 1'b1;
    step(3);
    compare("lamp_armed", 16'h0001, o_lamp);
  endtask : s_arm_guard

  // Release with throttle short of the on angle, then open it and time both stages
  task automatic s_stage_timing;
    i_rel_throttle = 8'h30;
    i_rpm = 16'h1388;
    i_arm_trigger = 1'b0;
    step(30);
    compare("relays_waiting", 16'h0000, {o_stage1_relay, o_stage2_relay});
    i_rel_throttle = 8'hC0;
    t1 = 0;
    t2 = 0;
    for (int n = 1; n <= 80; n++) begin
      step(1);
      if (o_stage2_relay === 1'b1 && t2 == 0) t2 = n;
      if (o_stage1_relay === 1'b1 && t1 == 0) t1 = n;
      // Only stage two on yet: its retard alone
      if (o_stage2_relay === 1'b1 && t1 == 0) compare("retard_one", 16'h0020, o_retard);
    end
    compare("stage2_delay", 16'h0001, 16'(t2 >= TICK && t2 <= 2 * TICK + 4));
    compare("stage1_delay", 16'h0001, 16'(t1 >= 4 * TICK && t1 <= 5 * TICK + 4));
    compare("short_first", 16'h0001, 16'(t2 < t1));
    compare("retard_both", 16'h0110, o_retard);
  endtask : s_stage_timing

  task automatic s_overspeed;
    i_rpm = i_max_rpm;
    step(2);
    compare("relays_max", 16'h0000, {o_stage1_relay, o_stage2_relay});
    i_rpm = 16'h1388;
    t1 = 0;
    for (int n = 1; n <= 60 && t1 == 0; n++) begin
      step(1);
      if (o_stage1_relay === 1'b1) t1 = n;
    end
    if (t1 == 0) begin
      fails++;
      $display("[ERR] reenable expected 1 seen 0");
      conclude();
    end else begin
      compare("reenable_delay", 16'h0001, 16'(t1 >= 2 * TICK && t1 <= 3 * TICK + 5));
    end
  endtask : s_overspeed

  task automatic s_stage_min;
    i_rpm = 16'h09C4;
    step(2);
    compare("stage_min", 16'h0002, {o_stage1_relay, o_stage2_relay});
    compare("retard_min", 16'h00F0, o_retard);
    i_rpm = 16'h1388;
    step(2);
    compare("stage_back", 16'h0003, {o_stage1_relay, o_stage2_relay});
  endtask : s_stage_min

  task automatic s_lift;
    i_rel_throttle = i_off_throttle;
    step(2);
    compare("relays_lift", 16'h0000, {o_stage1_relay, o_stage2_relay});
    i_rel_throttle = 8'hC0;
    step(40);
    compare("relays_stay", 16'h0000, {o_stage1_relay, o_stage2_relay, o_retard});
  endtask : s_lift

  // Hysteresis band edges: limit+1 cuts, limit-199 holds, limit-200 frees
  task automatic s_fuel;
    i_rpm = 16'h1771;
    step(3);
    compare("fuel_cut", 16'h0002, {o_fuel_cut_flag, o_inj_drive});
    i_rpm = 16'h16A9;
    step(3);
    compare("fuel_band", 16'h0002, {o_fuel_cut_flag, o_inj_drive});
    i_rpm = 16'h16A8;
    step(3);
    compare("fuel_back", 16'h0001, {o_fuel_cut_flag, o_inj_drive});
  endtask : s_fuel

  task automatic s_spark;
    i_rpm = 16'h1677;
    step(12);
    compare("spark_cut", 16'h0002, {o_spark_cut_flag, o_coil_fire});
    i_rpm = 16'h15AF;
    step(12);
    compare("spark_band", 16'h0002, {o_spark_cut_flag, o_coil_fire});
    i_rpm = 16'h15AE;
    step(12);
    compare("spark_back", 16'h0001, {o_spark_cut_flag, o_coil_fire});
    i_module_ignition_type = 1'b1;
    i_staging_trigger = 1'b1;
    i_rpm = 16'h1677;
    step(12);
    compare("module_fire", 16'h0001, {o_spark_cut_flag, o_coil_fire});
    i_module_ignition_type = 1'b0;
    i_rpm = 16'h1388;
    step(12);
    compare("staging_cut", 16'h0000, {o_spark_cut_flag, o_coil_fire});
    i_rpm = 16'h0BB8;
    step(12);
    compare("staging_free", 16'h0001, {o_spark_cut_flag, o_coil_fire});
  endtask : s_spark

  // ----------------
  // Clock and run
  // ----------------
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  initial begin
    fails = 0;
    comparisons = 0;
    i_srst = 1'b1;
    i_nitrous_enable = 1'b1;  // Closed at power-up on purpose
    i_arm_trigger = 1'b0;
    i_staging_trigger = 1'b0;
    i_module_ignition_type = 1'b0;
    i_rel_throttle = 8'h00;
    i_on_throttle = 8'h40;
    i_off_throttle = 8'h20;
    i_rpm = 16'h0000;
    i_max_rpm = 16'h1B58;
    i_reenable_ms = 16'h0003;
    i_stage1_min_rpm = 16'h07D0;
    i_stage2_min_rpm = 16'h0BB8;
    i_stage1_delay_ms = 16'h0005;
    i_stage2_delay_ms = 16'h0002;
    i_stage1_retard = 8'hF0;
    i_stage2_retard = 8'h20;
    i_fuel_limit = 16'h1770;
    i_spark_limit = 16'h1676;
    i_staging_rpm = 16'h0FA0;
    step(10);
    i_srst = 1'b0;
    step(2);
    s_arm_guard();
    s_stage_timing();
    s_overspeed();
    s_stage_min();
    s_lift();
    s_fuel();
    s_spark();
    conclude();
  end
endmodule : nitrous_stage_rev_limiter_test

`default_nettype wire

// ==== dv/nos_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nos_cfg.svh"

// ------------------------------
// Checker on the top-level ports
// ------------------------------
module nos_monitor (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_srst,
  // Inputs seen at the pins
  input wire logic        i_cyl_event,
  input wire logic        i_module_ignition_type,
  input wire logic        i_coil_req,
  input wire logic [15:0] i_rpm,
  input wire logic [15:0] i_max_rpm,
  input wire logic [15:0] i_stage1_min_rpm,
  input wire logic [15:0] i_fuel_limit,
  input wire logic [15:0] i_spark_limit,
  input wire logic [7:0]  i_rel_throttle,
  input wire logic [7:0]  i_off_throttle,
  input wire logic [7:0]  i_stage1_retard,
  input wire logic [7:0]  i_stage2_retard,
  // Outputs under watch
  input wire logic        o_stage1_relay,
  input wire logic        o_stage2_relay,
  input wire logic        o_lamp,
  input wire logic [8:0]  o_retard,
  input wire logic        o_inj_drive,
  input wire logic        o_fuel_cut_flag,
  input wire logic        o_coil_fire,
  input wire logic        o_spark_cut_flag
);
  logic [1:0] age;      // Edges since reset left
  logic       settled;  // Outputs now follow inputs

  // Outputs lag reset release by a couple of edges; keep checks quiet then
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  assign settled = (age == 2'h3);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  property p_fuel_cut; settled && i_rpm > i_fuel_limit |=> o_fuel_cut_flag; endproperty
  a_fuel_cut: assert property (p_fuel_cut) else $error("fuel cut late");
  property p_fuel_clear; settled && i_fuel_limit >= `NOS_HYST_RPM
    && i_rpm <= i_fuel_limit - `NOS_HYST_RPM |=> !o_fuel_cut_flag; endproperty
  a_fuel_clear: assert property (p_fuel_clear) else $error("fuel not resumed");
  property p_fuel_hold; settled && i_fuel_limit >= `NOS_HYST_RPM && i_rpm <= i_fuel_limit
    && i_rpm > i_fuel_limit - `NOS_HYST_RPM |=> $stable(o_fuel_cut_flag); endproperty
  a_fuel_hold: assert property (p_fuel_hold) else $error("fuel band moved");
  property p_fuel_total; settled && o_fuel_cut_flag && $past(o_fuel_cut_flag) |-> !o_inj_drive;
  endproperty
  a_fuel_total: assert property (p_fuel_total) else $error("fuel during cut");
  property p_spark_cut; settled && i_cyl_event && !i_module_ignition_type
    && i_rpm > i_spark_limit |-> ##2 o_spark_cut_flag; endproperty
  a_spark_cut: assert property (p_spark_cut) else $error("spark cut late");
  // Flag trails the deciding event by two edges
  property p_spark_event; settled && $rose(o_spark_cut_flag)
    |-> $past(i_cyl_event, 2); endproperty
  a_spark_event: assert property (p_spark_event) else $error("cut off event");
  property p_coil_cut; settled && o_spark_cut_flag && $past(o_spark_cut_flag)
    && !i_module_ignition_type && !$past(i_module_ignition_type) |-> !o_coil_fire; endproperty
  a_coil_cut: assert property (p_coil_cut) else $error("coil fired in cut");
  property p_module_fire; settled && $past(i_module_ignition_type) && $past(i_coil_req)
    && $past(i_module_ignition_type, 2) && $past(i_module_ignition_type, 3) |-> o_coil_fire;
  endproperty
  a_module_fire: assert property (p_module_fire) else $error("coil cut on module");
  property p_retard_sum; settled |-> o_retard ==
    (o_stage1_relay ? {1'b0, $past(i_stage1_retard)} : 9'h000) +
    (o_stage2_relay ? {1'b0, $past(i_stage2_retard)} : 9'h000); endproperty
  a_retard_sum: assert property (p_retard_sum) else $error("retard sum wrong");
  property p_lift_off; settled && i_rel_throttle <= i_off_throttle
    |=> !o_stage1_relay && !o_stage2_relay; endproperty
  a_lift_off: assert property (p_lift_off) else $error("relay on after lift");
  property p_max_off; settled && i_rpm >= i_max_rpm |=> !o_stage1_relay && !o_stage2_relay;
  endproperty
  a_max_off: assert property (p_max_off) else $error("relay on overspeed");
  property p_stage_min; settled && i_rpm < i_stage1_min_rpm |=> !o_stage1_relay; endproperty
  a_stage_min: assert property (p_stage_min) else $error("stage below min");
  property p_lamp_ready; o_lamp |-> !o_stage1_relay && !o_stage2_relay; endproperty
  a_lamp_ready: assert property (p_lamp_ready) else $error("lamp with relay");

  // Main scenarios reached
  c_fuel_cut: cover property (o_fuel_cut_flag);
  c_both_stages: cover property (o_stage1_relay && o_stage2_relay);
  c_spark_cut: cover property ($rose(o_spark_cut_flag));
endmodule : nos_monitor

bind nitrous_stage_rev_limiter nos_monitor monitor_u (.*);

`default_nettype wire

// ==== dv/nos_partner.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------
// Engine side: crank events, injector and coil asks
// ------------------------------------------------
module nos_partner (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_srst,
  // Requests into the limiter
  output logic      o_cyl_event,
  output logic      o_inj_req,
  output logic      o_coil_req
);
  logic [2:0] phase;  // Crank position between events

  initial begin
    phase       = 3'h0;
    o_cyl_event = 1'b0;
    o_inj_req   = 1'b0;
    o_coil_req  = 1'b0;
  end

  // One event in eight cycles; moved off the sampling edge
  always @(negedge i_clk) begin
    phase       <= i_srst ? 3'h0 : phase + 3'h1;
    o_cyl_event <= !i_srst && (phase == 3'h7);
    o_inj_req   <= !i_srst;  // Base strategy always asks for fuel
    o_coil_req  <= !i_srst;  // And for spark
  end
endmodule : nos_partner

`default_nettype wire

// ==== hw/nitrous_stage_rev_limiter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nos_cfg.svh"

// Function
// - Two stages, each on after own delay
// - Enable closed at power-up needs off-on
// - Press arms; release waits to start both timers
// - Lamp lit while armed and ready
// - Delays count whole milliseconds
// - Subtract summed retard of active stages
// - Stage timers run independently
// - Timing waits for throttle and speed
// - Throttle at off angle shuts nitrous
// - Reaching maximum speed shuts nitrous
// - Over-speed re-enable after delay below max
// - Throttle lift ends nitrous for run
// - Stage held off below its minimum speed
// - Fuel cut above limit, resume -200
// - Fuel cut is total
// - Spark cut per event, resume -200
// - Module ignition type: no spark cut
// - Staging trigger cuts spark at staging speed
module nitrous_stage_rev_limiter #(
  parameter int TICK_CYCLES = `NOS_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_srst,
  // Switches
  input  wire logic                   i_nitrous_enable,
  input  wire logic                   i_arm_trigger,
  input  wire logic                   i_staging_trigger,
  input  wire logic                   i_module_ignition_type,
  // Sensors
  input  wire logic [`NOS_TP_W-1:0]   i_rel_throttle,
  input  wire logic [`NOS_RPM_W-1:0]  i_rpm,
  input  wire logic                   i_cyl_event,
  // Nitrous calibration
  input  wire logic [`NOS_TP_W-1:0]   i_on_throttle,
  input  wire logic [`NOS_TP_W-1:0]   i_off_throttle,
  input  wire logic [`NOS_RPM_W-1:0]  i_max_rpm,
  input  wire logic [`NOS_MS_W-1:0]   i_reenable_ms,
  input  wire logic [`NOS_RPM_W-1:0]  i_stage1_min_rpm,
  input  wire logic [`NOS_RPM_W-1:0]  i_stage2_min_rpm,
  input  wire logic [`NOS_MS_W-1:0]   i_stage1_delay_ms,
  input  wire logic [`NOS_MS_W-1:0]   i_stage2_delay_ms,
  input  wire logic [`NOS_SPK_W-1:0]  i_stage1_retard,
  input  wire logic [`NOS_SPK_W-1:0]  i_stage2_retard,
  // Limiter calibration
  input  wire logic [`NOS_RPM_W-1:0]  i_fuel_limit,
  input  wire logic [`NOS_RPM_W-1:0]  i_spark_limit,
  input  wire logic [`NOS_RPM_W-1:0]  i_staging_rpm,
  // Injector and coil requests from base strategy
  input  wire logic                   i_inj_req,
  input  wire logic                   i_coil_req,
  // Nitrous outputs
  output logic                        o_stage1_relay,
  output logic                        o_stage2_relay,
  output logic                        o_lamp,
  output logic [`NOS_SPK_W:0]         o_retard,
  // Limiter outputs
  output logic                        o_inj_drive,
  output logic                        o_fuel_cut_flag,
  output logic                        o_coil_fire,
  output logic                        o_spark_cut_flag
);

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  // --------------------------------------------------------------------------
  // Millisecond tick
  // --------------------------------------------------------------------------
  logic [31:0] tick_cnt;   // Cycle prescaler
  logic        ms_tick;    // One-cycle pulse every ms

  // Free-running divider; a ms may start mid-count, so delays are +0/-1 ms
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tick_cnt <= '0;
      ms_tick  <= 1'b0;
    end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      ms_tick  <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      ms_tick  <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Enable switch power-up guard
  // --------------------------------------------------------------------------
  logic enable_seen_off;   // Enable has been open since reset

  // Arming is refused until the switch is seen open once
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      enable_seen_off <= 1'b0;
    end else if (!i_nitrous_enable) begin
      enable_seen_off <= 1'b1;
    end
  end

  logic sys_enabled;
  assign sys_enabled = i_nitrous_enable && enable_seen_off;

  // --------------------------------------------------------------------------
  // Shared conditions
  // --------------------------------------------------------------------------
  logic tp_on_ok;     // Throttle above on angle
  logic tp_lift;      // Throttle at or below off angle
  logic overspeed;    // At or above max speed
  assign tp_on_ok  = i_rel_throttle > i_on_throttle;
  assign tp_lift   = i_rel_throttle <= i_off_throttle;
  assign overspeed = i_rpm >= i_max_rpm;

  // Lowest stage minimum gates the start of timing
  logic [`NOS_RPM_W-1:0] min_rpm;
  assign min_rpm = (i_stage1_min_rpm < i_stage2_min_rpm) ? i_stage1_min_rpm
                                                         : i_stage2_min_rpm;

  // --------------------------------------------------------------------------
  // Stage timers
  // --------------------------------------------------------------------------
  stage_if sif ();
  nos_pkg::seq_state_t state;
  nos_pkg::seq_state_t next_state;
  logic                timers_clear;

  assign sif.tick  = ms_tick;
  assign sif.run   = (state == nos_pkg::ST_TIMING);
  assign sif.clear = timers_clear;

  stage_timers #(
    .NSTAGE (2)
  ) u_timers (
    .i_clk      (i_clk),
    .i_srst     (i_srst),
    .i_delay_ms ({i_stage2_delay_ms, i_stage1_delay_ms}),
    .sif        (sif)
  );

  // --------------------------------------------------------------------------
  // Re-enable delay after over-speed
  // --------------------------------------------------------------------------
  logic [`NOS_MS_W-1:0] reen_cnt;   // Ms spent below max speed
  logic                 reen_done;
  assign reen_done = reen_cnt >= i_reenable_ms;

  // Counts only below max; restarts on any new over-speed
  always_ff @(posedge i_clk) begin
    if (i_srst || state != nos_pkg::ST_OVERSPD || overspeed) begin
      reen_cnt <= '0;
    end else if (ms_tick && !reen_done) begin
      reen_cnt <= reen_cnt + 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_state   = state;
    timers_clear = 1'b0;
    case (state)
      nos_pkg::ST_IDLE: begin
        if (sys_enabled && i_arm_trigger) begin
          next_state = nos_pkg::ST_ARMED;
        end
      end
      nos_pkg::ST_ARMED: begin
        timers_clear = 1'b1;
        if (!sys_enabled) begin
          next_state = nos_pkg::ST_IDLE;
        end else if (!i_arm_trigger) begin
          next_state = nos_pkg::ST_WAIT;
        end
      end
      nos_pkg::ST_WAIT: begin
        // Start only once throttle and speed qualify
        if (!sys_enabled) begin
          next_state = nos_pkg::ST_IDLE;
        end else if (tp_on_ok && i_rpm > min_rpm && !overspeed) begin
          next_state = nos_pkg::ST_TIMING;
        end
      end
      nos_pkg::ST_TIMING: begin
        if (!sys_enabled) begin
          next_state = nos_pkg::ST_IDLE;
        end else if (tp_lift) begin
          next_state = nos_pkg::ST_DONE;
        end else if (overspeed) begin
          next_state = nos_pkg::ST_OVERSPD;
        end
      end
      nos_pkg::ST_OVERSPD: begin
        // Timers keep their state so stages come back together
        if (!sys_enabled) begin
          next_state = nos_pkg::ST_IDLE;
        end else if (tp_lift) begin
          next_state = nos_pkg::ST_DONE;
        end else if (!overspeed && reen_done) begin
          next_state = nos_pkg::ST_TIMING;
        end
      end
      nos_pkg::ST_DONE: begin
        // Run over until the enable switch is opened
        timers_clear = 1'b1;
        if (!i_nitrous_enable) begin
          next_state = nos_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = nos_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= nos_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------------
  // Stage outputs and retard
  // --------------------------------------------------------------------------
  logic next_s1;   // Stage 1 may be on
  logic next_s2;   // Stage 2 may be on
  assign next_s1 = (next_state == nos_pkg::ST_TIMING) && sif.elapsed[0]
                   && (i_rpm >= i_stage1_min_rpm);
  assign next_s2 = (next_state == nos_pkg::ST_TIMING) && sif.elapsed[1]
                   && (i_rpm >= i_stage2_min_rpm);

  // Relays follow latched timer result until shutoff
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_stage1_relay <= 1'b0;
      o_stage2_relay <= 1'b0;
    end else begin
      o_stage1_relay <= next_s1;
      o_stage2_relay <= next_s2;
    end
  end

  // Sum of active retards, one bit wider to never wrap
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_retard <= '0;
    end else begin
      o_retard <= (next_s1 ? {1'b0, i_stage1_retard} : 9'h000)
                + (next_s2 ? {1'b0, i_stage2_retard} : 9'h000);
    end
  end

  // Lamp while armed and waiting to fire
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_lamp <= 1'b0;
    end else begin
      o_lamp <= (next_state == nos_pkg::ST_ARMED)
             || (next_state == nos_pkg::ST_WAIT);
    end
  end

  // --------------------------------------------------------------------------
  // Fuel limiter
  // --------------------------------------------------------------------------
  logic fuel_cut;
  logic next_fuel_cut;
  always_comb begin
    next_fuel_cut = fuel_cut;
    if (i_rpm > i_fuel_limit) begin
      next_fuel_cut = 1'b1;
    end else if (i_rpm <= i_fuel_limit - `NOS_HYST_RPM) begin
      next_fuel_cut = 1'b0;
    end
  end

  // Cut is all or nothing; no lean-out
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      fuel_cut        <= 1'b0;
      o_fuel_cut_flag <= 1'b0;
      o_inj_drive     <= 1'b0;
    end else begin
      fuel_cut        <= next_fuel_cut;
      o_fuel_cut_flag <= next_fuel_cut;
      o_inj_drive     <= i_inj_req && !next_fuel_cut;
    end
  end

  // --------------------------------------------------------------------------
  // Spark and staging limiters, decided once per cylinder event
  // --------------------------------------------------------------------------
  logic spark_cut;   // Hysteretic rev limit state
  logic stage_cut;   // Staging limiter decision for this event
  always_ff @(posedge i_clk) begin
    if (i_srst || i_module_ignition_type) begin
      spark_cut <= 1'b0;
      stage_cut <= 1'b0;
    end else if (i_cyl_event) begin
      if (i_rpm > i_spark_limit) begin
        spark_cut <= 1'b1;
      end else if (i_rpm <= i_spark_limit - `NOS_HYST_RPM) begin
        spark_cut <= 1'b0;
      end
      stage_cut <= i_staging_trigger && (i_rpm > i_staging_rpm);
    end
  end

  // Coil gating; module ignition never sees a cut
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_coil_fire      <= 1'b0;
      o_spark_cut_flag <= 1'b0;
    end else begin
      o_coil_fire      <= i_coil_req && !spark_cut && !stage_cut;
      o_spark_cut_flag <= spark_cut;
    end
  end

endmodule : nitrous_stage_rev_limiter

`default_nettype wire

// ==== hw/nos_cfg.svh ====
`ifndef NOS_CFG_SVH
`define NOS_CFG_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define NOS_CLK_MHZ       250
`define NOS_TICK_US       1000
`define NOS_TICK_CYCLES   (`NOS_CLK_MHZ * `NOS_TICK_US)

// ----------------------------------------------------------------------------
// Limiter hysteresis and field widths
// ----------------------------------------------------------------------------
`define NOS_HYST_RPM      16'h00C8
`define NOS_RPM_W         16
`define NOS_MS_W          16
`define NOS_TP_W          8
`define NOS_SPK_W         8

`endif

// ==== hw/nos_pkg.sv ====
package nos_pkg;

  // --------------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARMED,
    ST_WAIT,
    ST_TIMING,
    ST_OVERSPD,
    ST_DONE
  } seq_state_t;

endpackage : nos_pkg

// ==== hw/stage_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// Carrier between sequencer and the per-stage timers
interface stage_if;
  logic       tick;      // One-millisecond strobe
  logic       run;       // Timers counting
  logic       clear;     // Restart timers from zero
  logic [1:0] elapsed;   // Per stage: delay reached

  modport seq   (output tick, output run, output clear, input elapsed);
  modport timer (input tick, input run, input clear, output elapsed);
endinterface : stage_if

`default_nettype wire

// ==== hw/stage_timers.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nos_cfg.svh"

// Two independent millisecond counters sharing one start
module stage_timers #(
  parameter int NSTAGE = 2
) (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_srst,
  // Programmed delays, stage 0 in low bits
  input  wire logic [NSTAGE*`NOS_MS_W-1:0] i_delay_ms,
  // Sequencer side
  stage_if.timer                       sif
);

  // Refused at elaboration: the carrier holds exactly two stages
  if (NSTAGE != 2) begin : g_bad_nstage
    $error("stage_timers: NSTAGE must be 2");
  end

  // --------------------------------------------------------------------------
  // One counter per stage
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NSTAGE; g++) begin : g_stage
      logic [`NOS_MS_W-1:0] cnt;   // Milliseconds since start
      logic                 done;  // Delay reached, held

      // Count ms ticks; stages never see each other
      always_ff @(posedge i_clk) begin
        if (i_srst || sif.clear) begin
          cnt  <= '0;
          done <= 1'b0;
        end else if (sif.run) begin
          if (cnt >= i_delay_ms[g*`NOS_MS_W +: `NOS_MS_W]) begin
            done <= 1'b1;
          end else if (sif.tick) begin
            cnt <= cnt + 16'h0001;
          end
        end
      end
      assign sif.elapsed[g] = done;
    end
  endgenerate

endmodule : stage_timers

`default_nettype wire
